// file: src/smd_pkg.sv
// Package of constants and types for the strap mode decoder.
// How it works
// - The two debug select bits decode 00 as boundary scan, 11 as emulation, 01 and 10 as reserved.
// - Functional operation is allowed under both the boundary-scan code and the emulation code.
// - The boot select decodes 00 as emulation boot, 01 as 8-bit ROM boot, 10 as 16-bit ROM boot.
// - Undriven straps read as debug code 11 and boot code 01.
// - Byte order select 1 means little endian, 0 means big endian where supported.
package smd_pkg;
	localparam logic [1:0] SMD_DBG_SCAN = 2'h0;
	localparam logic [1:0] SMD_DBG_EMU = 2'h3;
	localparam logic [1:0] SMD_BOOT_EMU = 2'h0;
	localparam logic [1:0] SMD_BOOT_ROM8 = 2'h1;
	localparam logic [1:0] SMD_BOOT_ROM16 = 2'h2;
	localparam logic [1:0] SMD_BOOT_RSVD = 2'h3;
	localparam logic [1:0] SMD_DBG_RST = SMD_DBG_EMU;
	localparam logic [1:0] SMD_BOOT_RST = SMD_BOOT_ROM8;
	localparam logic SMD_ORDER_LITTLE = 1'b1;
	localparam logic SMD_ORDER_RST = SMD_ORDER_LITTLE;
	localparam int SMD_STRAP_W = 6;
	localparam int SMD_HADDR_W = 32;
	localparam logic [31:0] SMD_OFS_MODE = 32'h0000_0000;
	localparam logic [31:0] SMD_OFS_STRAP = 32'h0000_0004;
	localparam logic [31:0] SMD_OFS_CTRL = 32'h0000_0008;
	localparam int SMD_MODE_SCAN_BIT = 0;
	localparam int SMD_MODE_EMU_BIT = 1;
	localparam int SMD_MODE_DBGRSV_BIT = 2;
	localparam int SMD_MODE_FUNC_BIT = 3;
	localparam int SMD_MODE_BOOT_LSB = 4;
	localparam int SMD_MODE_BOOTRSV_BIT = 6;
	localparam int SMD_MODE_BIG_BIT = 7;
	localparam int SMD_MODE_FIXERR_BIT = 8;
	localparam int SMD_MODE_LATCHED_BIT = 9;
	localparam logic [31:0] SMD_CTRL_RST = 32'h0000_0001;
	typedef enum logic [2:0] {
		SMD_ST_WAIT = 3'h1,
		SMD_ST_SETTLE = 3'h2,
		SMD_ST_HOLD = 3'h4
	} smd_state_t;
endpackage

// file: src/smd_sync.sv
// Three-flop synchroniser that reports a change once stages two and three agree.
`timescale 1ns/1ps
module smd_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] rst_val,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
	logic [W-1:0] nxt_out;

	always_comb begin
		nxt_out = out_ff;
		for (int i = 0; i < W; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_out[i] = s3_ff[i];
			end
		end
	end

	// Reset value is a constant from the parent, never a live pin
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			out_ff <= '0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign sync_out = out_ff ^ rst_val;
endmodule

// file: src/smd_top.sv
// Strap mode decoder: strap capture, decode and AHB-Lite status registers.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module smd_top #(
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] debug_mode_select,
	input wire logic [1:0] boot_select,
	input wire logic byte_order_select,
	input wire logic ext_bus_order_fix,
	input wire logic hsel,
	input wire logic [smd_pkg::SMD_HADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic mode_scan,
	output logic mode_emu,
	output logic mode_func,
	output logic [1:0] boot_mode,
	output logic boot_emu,
	output logic boot_rom8,
	output logic boot_rom16,
	output logic order_little,
	output logic cfg_valid,
	output logic cfg_error
);
	import smd_pkg::*;

	// Straps cross in through the synchroniser; reset values match undriven pins except ext_bus_order_fix, which resets low
	logic [SMD_STRAP_W-1:0] strap_raw;
	logic [SMD_STRAP_W-1:0] strap_sync;
	localparam logic [SMD_STRAP_W-1:0] STRAP_RST = {SMD_DBG_RST, SMD_BOOT_RST,
		SMD_ORDER_RST, 1'b0};

	assign strap_raw = {debug_mode_select, boot_select, byte_order_select,
		ext_bus_order_fix} ^ STRAP_RST;

	smd_sync #(.W(SMD_STRAP_W)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.rst_val(STRAP_RST),
		.pin_in(strap_raw),
		.sync_out(strap_sync)
	);

	// Latch sequence
	smd_state_t st_ff, nxt_st;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [1:0] dbg_ff, nxt_dbg;
	logic [1:0] boot_ff, nxt_boot;
	logic order_ff, nxt_order;
	logic latched_ff, nxt_latched;
	logic fix_err_ff, nxt_fix_err;
	logic func_en_ff, nxt_func_en;

	function automatic logic dbg_is_rsv(input logic [1:0] c);
		return (c != SMD_DBG_SCAN) && (c != SMD_DBG_EMU);
	endfunction

	// Settle lets the synchroniser flush after release before the capture
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_dbg = dbg_ff;
		nxt_boot = boot_ff;
		nxt_order = order_ff;
		nxt_latched = latched_ff;
		nxt_fix_err = fix_err_ff;
		case (st_ff)
			SMD_ST_WAIT: begin
				nxt_st = SMD_ST_SETTLE;
				nxt_cnt = 8'h0;
			end
			SMD_ST_SETTLE: begin
				if (cnt_ff >= 8'(SETTLE_CYCLES - 1)) begin
					nxt_st = SMD_ST_HOLD;
					nxt_dbg = strap_sync[5:4];
					nxt_boot = strap_sync[3:2];
					nxt_order = strap_sync[1];
					nxt_latched = 1'b1;
					// Board must hold the fix input low in big endian
					nxt_fix_err = !strap_sync[1] && strap_sync[0];
				end else begin
					nxt_cnt = cnt_ff + 8'h1;
				end
			end
			SMD_ST_HOLD: begin
				nxt_st = SMD_ST_HOLD;
			end
			default: begin
				nxt_st = SMD_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= SMD_ST_WAIT;
			cnt_ff <= 8'h0;
			dbg_ff <= SMD_DBG_RST;
			boot_ff <= SMD_BOOT_RST;
			order_ff <= SMD_ORDER_RST;
			latched_ff <= 1'b0;
			fix_err_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			dbg_ff <= nxt_dbg;
			boot_ff <= nxt_boot;
			order_ff <= nxt_order;
			latched_ff <= nxt_latched;
			fix_err_ff <= nxt_fix_err;
		end
	end

	// Decoded mode outputs, all registered
	logic n_scan, n_emu, n_func, n_bemu, n_b8, n_b16, n_little, n_err;
	logic [1:0] n_bmode;
	logic scan_ff, emu_ff, func_ff, bemu_ff, b8_ff, b16_ff, little_ff, valid_ff, err_ff;
	logic [1:0] bmode_ff;

	always_comb begin
		n_scan = dbg_ff == SMD_DBG_SCAN;
		n_emu = dbg_ff == SMD_DBG_EMU;
		// Functional in either valid debug code, gated by software enable
		n_func = (n_scan || n_emu) && func_en_ff;
		n_bemu = boot_ff == SMD_BOOT_EMU;
		n_b8 = boot_ff == SMD_BOOT_ROM8;
		n_b16 = boot_ff == SMD_BOOT_ROM16;
		// Reserved boot code passes through and is flagged as an error
		n_bmode = boot_ff;
		n_little = order_ff == SMD_ORDER_LITTLE;
		n_err = dbg_is_rsv(dbg_ff) || (boot_ff == SMD_BOOT_RSVD) || fix_err_ff;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scan_ff <= 1'b0;
			emu_ff <= 1'b0;
			func_ff <= 1'b0;
			bmode_ff <= SMD_BOOT_RST;
			bemu_ff <= 1'b0;
			b8_ff <= 1'b0;
			b16_ff <= 1'b0;
			little_ff <= SMD_ORDER_RST;
			valid_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			scan_ff <= n_scan && latched_ff;
			emu_ff <= n_emu && latched_ff;
			func_ff <= n_func && latched_ff;
			bmode_ff <= n_bmode;
			bemu_ff <= n_bemu && latched_ff;
			b8_ff <= n_b8 && latched_ff;
			b16_ff <= n_b16 && latched_ff;
			little_ff <= n_little;
			valid_ff <= latched_ff;
			err_ff <= n_err && latched_ff;
		end
	end

	assign mode_scan = scan_ff;
	assign mode_emu = emu_ff;
	assign mode_func = func_ff;
	assign boot_mode = bmode_ff;
	assign boot_emu = bemu_ff;
	assign boot_rom8 = b8_ff;
	assign boot_rom16 = b16_ff;
	assign order_little = little_ff;
	assign cfg_valid = valid_ff;
	assign cfg_error = err_ff;

	// AHB-Lite slave, zero wait states, always OKAY
	logic aph_ff, nxt_aph;
	logic wr_ff, nxt_wr;
	logic [31:0] adr_ff, nxt_adr;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [31:0] mode_word, strap_word;

	always_comb begin
		mode_word = '0;
		mode_word[SMD_MODE_SCAN_BIT] = scan_ff;
		mode_word[SMD_MODE_EMU_BIT] = emu_ff;
		mode_word[SMD_MODE_DBGRSV_BIT] = latched_ff && dbg_is_rsv(dbg_ff);
		mode_word[SMD_MODE_FUNC_BIT] = func_ff;
		mode_word[SMD_MODE_BOOT_LSB +: 2] = bmode_ff;
		mode_word[SMD_MODE_BOOTRSV_BIT] = latched_ff && (boot_ff == SMD_BOOT_RSVD);
		mode_word[SMD_MODE_BIG_BIT] = !little_ff;
		mode_word[SMD_MODE_FIXERR_BIT] = fix_err_ff;
		mode_word[SMD_MODE_LATCHED_BIT] = latched_ff;
		strap_word = {26'h0, strap_sync};
	end

	always_comb begin
		nxt_aph = hsel && htrans[1] && hready;
		nxt_wr = hwrite;
		nxt_adr = haddr;
		nxt_func_en = func_en_ff;
		nxt_rdata = 32'h0;
		if (aph_ff && wr_ff && adr_ff == SMD_OFS_CTRL) begin
			nxt_func_en = hwdata[0];
		end
		if (nxt_aph && !hwrite) begin
			case (haddr)
				SMD_OFS_MODE: nxt_rdata = mode_word;
				SMD_OFS_STRAP: nxt_rdata = strap_word;
				SMD_OFS_CTRL: nxt_rdata = {31'h0, func_en_ff};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aph_ff <= 1'b0;
			wr_ff <= 1'b0;
			adr_ff <= 32'h0;
			rdata_ff <= 32'h0;
			func_en_ff <= SMD_CTRL_RST[0];
		end else begin
			aph_ff <= nxt_aph;
			wr_ff <= nxt_wr;
			adr_ff <= nxt_adr;
			rdata_ff <= nxt_rdata;
			func_en_ff <= nxt_func_en;
		end
	end

	assign hrdata = rdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule

// file: dv/smd_properties.sv
// Checker for the strap mode decoder outputs.
`timescale 1ns/1ps
module smd_properties import smd_pkg::*; #(
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mode_scan,
	input wire logic mode_emu,
	input wire logic mode_func,
	input wire logic [1:0] boot_mode,
	input wire logic boot_emu,
	input wire logic boot_rom8,
	input wire logic boot_rom16,
	input wire logic order_little,
	input wire logic cfg_valid,
	input wire logic cfg_error
);
	// Sync chain plus settle count, with margin
	localparam int MAXV = SETTLE_CYCLES + 8;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_scan_emu_excl: assert property (!(mode_scan && mode_emu))
		else $error("scan and emulation both set");
	a_rsvd_dbg_err: assert property (cfg_valid && !mode_scan && !mode_emu |-> cfg_error)
		else $error("reserved debug code not flagged");
	a_func_needs_code: assert property (mode_func |-> mode_scan || mode_emu)
		else $error("functional without a valid debug code");
	a_boot_decode: assert property (cfg_valid |-> {boot_emu, boot_rom8, boot_rom16} ==
		{boot_mode == SMD_BOOT_EMU, boot_mode == SMD_BOOT_ROM8, boot_mode == SMD_BOOT_ROM16})
		else $error("boot decode mismatch");
	a_rsvd_boot_err: assert property (cfg_valid && boot_mode == SMD_BOOT_RSVD |-> cfg_error)
		else $error("reserved boot code not flagged");
	a_reset_dflt: assert property ($rose(rst_n) |-> boot_mode == SMD_BOOT_RST && order_little && !cfg_valid)
		else $error("latch before release or wrong reset value");
	a_valid_soon: assert property ($rose(rst_n) |-> ##[1:MAXV] cfg_valid)
		else $error("straps never latched");
	a_modes_held: assert property ($past(cfg_valid) && cfg_valid |->
		$stable({mode_scan, mode_emu, boot_mode, order_little, cfg_error}))
		else $error("latched mode moved");
	c_scan: cover property (cfg_valid && mode_scan);
	c_err: cover property (cfg_valid && cfg_error);
	c_rom16: cover property (cfg_valid && boot_rom16);
endmodule
bind smd_top smd_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_smd_properties (.mclk(mclk),
	.rst_n(rst_n), .mode_scan(mode_scan), .mode_emu(mode_emu), .mode_func(mode_func),
	.boot_mode(boot_mode), .boot_emu(boot_emu), .boot_rom8(boot_rom8), .boot_rom16(boot_rom16),
	.order_little(order_little), .cfg_valid(cfg_valid), .cfg_error(cfg_error));

// file: dv/smd_board.sv
// Board strap model: driven codes, or pull levels when left open.
`timescale 1ns/1ps
module smd_board (
	input wire logic drive,
	input wire logic brk,
	input wire logic [5:0] val,
	output logic [1:0] debug_mode_select,
	output logic [1:0] boot_select,
	output logic byte_order_select,
	output logic ext_bus_order_fix
);
	import smd_pkg::*;
	assign debug_mode_select = drive ? val[5:4] : SMD_DBG_RST;
	// Reserved boot code only when a test asks for it
	assign boot_select = !drive ? SMD_BOOT_RST :
		(&val[3:2] && !brk) ? SMD_BOOT_ROM8 : val[3:2];
	assign byte_order_select = drive ? val[1] : SMD_ORDER_RST;
	assign ext_bus_order_fix = !drive | ((val[1] | brk) & val[0]);
	// No test reset pin here, so its pulldown is never opposed
endmodule

// file: dv/testbench.sv
// Bench: strap sweep over resets, bus reads of the latched modes.
`timescale 1ns/1ps
module testbench;
	import smd_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, drive = 1'b0, brk = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic dph = 1'b0, cfg_q = 1'b0, byte_order_select, ext_bus_order_fix, hreadyout, hresp;
	logic mode_scan, mode_emu, mode_func, boot_emu, boot_rom8, boot_rom16, order_little;
	logic cfg_valid, cfg_error;
	logic [1:0] debug_mode_select, boot_select, boot_mode, htrans = 2'h0;
	logic [5:0] val = 6'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [9:0] mode_q[$];
	logic [31:0] rd_q[$];
	int bad_count = 0, samples_checked = 0, cyc = 0;
	initial forever #5 mclk = ~mclk;
	smd_board u_smd_board (.drive, .brk, .val, .debug_mode_select, .boot_select,
		.byte_order_select, .ext_bus_order_fix);
	smd_top u_smd_top (.mclk, .rst_n, .debug_mode_select, .boot_select, .byte_order_select,
		.ext_bus_order_fix, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode_scan, .mode_emu, .mode_func,
		.boot_mode, .boot_emu, .boot_rom8, .boot_rom16, .order_little, .cfg_valid, .cfg_error);
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		samples_checked++;
		if (e !== s) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_mode(logic [9:0] e);
		chk("modes", {22'h0, e}, {22'h0, mode_scan, mode_emu, mode_func, boot_mode, boot_emu,
			boot_rom8, boot_rom16, order_little, cfg_error});
	endtask
	task automatic cmp_rd(logic [31:0] e);
		chk("hrdata", e, hrdata);
		// Slave must always answer OKAY
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task summarize;
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] mode_reg(logic [5:0] v, logic fen);
		logic [31:0] r;
		r = 32'h0;
		r[SMD_MODE_SCAN_BIT] = v[5:4] == SMD_DBG_SCAN;
		r[SMD_MODE_EMU_BIT] = v[5:4] == SMD_DBG_EMU;
		r[SMD_MODE_DBGRSV_BIT] = ^v[5:4];
		r[SMD_MODE_FUNC_BIT] = fen & ~^v[5:4];
		r[SMD_MODE_BOOT_LSB +: 2] = v[3:2];
		r[SMD_MODE_BOOTRSV_BIT] = &v[3:2];
		r[SMD_MODE_BIG_BIT] = ~v[1];
		r[SMD_MODE_FIXERR_BIT] = ~v[1] & v[0];
		r[SMD_MODE_LATCHED_BIT] = 1'b1;
		return r;
	endfunction
	task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		dph <= ~w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		dph <= 1'b0;
	endtask
	always @(posedge mclk) begin
		cfg_q <= cfg_valid;
		if (cfg_valid === 1'b1 && cfg_q !== 1'b1) cmp_mode(mode_q.pop_front());
		if (dph && hreadyout === 1'b1) cmp_rd(rd_q.pop_front());
		cyc++;
		if (cyc > 6000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		logic [5:0] v;
		logic k;
		void'($urandom(11));
		for (int i = 0; i <= 32; i++) begin
			// Every debug, boot and order code; fix pin random but held low in big endian without a fault, fault choice random except forced on for boot code 11
			k = (i[2:1] == 2'h3) | 1'($urandom_range(1));
			v = {i[4:1], i[0], 1'($urandom_range(1))};
			if (!(v[1] | k)) v[0] = 1'b0;
			if (i == 32) v = {SMD_DBG_RST, SMD_BOOT_RST, SMD_ORDER_RST, 1'b1};
			rst_n <= 1'b0;
			drive <= i < 32;
			brk <= k;
			val <= v;
			repeat (5) @(posedge mclk);
			mode_q.push_back({v[5:4] == SMD_DBG_SCAN, v[5:4] == SMD_DBG_EMU, ~^v[5:4], v[3:2],
				v[3:2] == SMD_BOOT_EMU, v[3:2] == SMD_BOOT_ROM8, v[3:2] == SMD_BOOT_ROM16, v[1],
				^v[5:4] | &v[3:2] | (~v[1] & v[0])});
			rst_n <= 1'b1;
			wait (cfg_valid === 1'b1);
			@(posedge mclk);
			// Straps move after the latch; the modes must not
			val <= 6'($urandom);
			rd_q.push_back(mode_reg(v, 1'b1));
			bus(1'b0, SMD_OFS_MODE, 32'h0);
			bus(1'b1, SMD_OFS_CTRL, 32'h0);
			rd_q.push_back(mode_reg(v, 1'b0));
			bus(1'b0, SMD_OFS_MODE, 32'h0);
			rd_q.push_back(32'h0);
			bus(1'b0, SMD_OFS_CTRL, 32'h0);
			rd_q.push_back(32'h0);
			bus(1'b0, 32'h0000_000c, 32'h0);
			// Live straps have long passed the synchroniser by now
			rd_q.push_back({26'h0, debug_mode_select, boot_select, byte_order_select,
				ext_bus_order_fix});
			bus(1'b0, SMD_OFS_STRAP, 32'h0);
		end
		summarize();
	end
endmodule
